// File: flash_block_page_status.sv
// flash array block with ecc read status and page status reporting
// assumes one clock, synchronous reset, classic wishbone register access
//
// Behaviour
// - single-bit error corrected returns status 01
// - double-bit error returns 10, data uncorrected
// - write count in 31:8, reserved 7:4 zero
// - over-threshold indicator reported in bit 3
// - read-protect flag reported in bit 2
// - write-protect flag reported in bit 1
// - lock flag set when programmed with lock
// - locked page refuses programs until released
`timescale 1ns/1ns
`default_nettype none
module flash_block_page_status
#(
  parameter int PAGES = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  import page_status_pkg::*;

  localparam int PW = $clog2(PAGES);

  // pages must be a power of two no wider than the address field, or a read
  // indexes past the end of the arrays
  if (PAGES < 2 || PAGES > (1 << ADDR_W) || (1 << PW) != PAGES)
  begin : g_pages_check
    $error("PAGES out of range");
  end

  // data words carry a 2-bit error injection field for test purposes;
  // real ecc syndrome logic lives in the array macro
  logic [31:0] data_mem [PAGES];
  logic [1:0] err_mem [PAGES];
  page_meta_t meta [PAGES];

  logic [PW-1:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rstat_reg;
  logic refused_reg;
  logic [EV_W-1:0] irq_reg;
  logic [EV_W-1:0] mask_reg;
  logic [3:0] prot_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  logic req;
  logic wr;
  logic [31:0] ctrl_wr;
  logic do_read;
  logic do_prog;
  logic do_unlock;
  logic page_info;
  logic [EV_W-1:0] ev;
  page_meta_t cur;
  // assertion view of the addressed word and its stored error code
  logic [31:0] cur_word;
  logic [1:0] cur_err;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign ctrl_wr = (wr && wb_adr_i == OFS_CTRL) ? wb_dat_i : 32'h0;
  assign do_read = ctrl_wr[CMD_READ];
  assign page_info = ctrl_wr[CMD_PAGEINFO];
  assign do_prog = ctrl_wr[CMD_PROG];
  assign do_unlock = ctrl_wr[CMD_UNLOCK];
  assign cur = meta[addr_reg];
  assign cur_word = data_mem[addr_reg];
  assign cur_err = err_mem[addr_reg];

  // wishbone ack: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_reg <= '0;
      wdata_reg <= 32'h0;
      prot_reg <= 4'h0;
      mask_reg <= MASK_RST;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        OFS_ADDR: addr_reg <= wb_dat_i[PW-1:0];
        OFS_WDATA: wdata_reg <= wb_dat_i;
        OFS_MASK: mask_reg <= wb_dat_i[EV_W-1:0];
        // bits 1:0 set rd/wr protect, 3:2 inject ecc error on every program until rewritten
        OFS_PROT: prot_reg <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // array and per-page metadata
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < PAGES; i++)
      begin
        data_mem[i] <= 32'h0;
        err_mem[i] <= 2'h0;
        meta[i] <= '0;
      end
    end
    else if (do_unlock)
      meta[addr_reg].locked <= 1'b0;
    else if (do_prog && !cur.locked)
    begin
      data_mem[addr_reg] <= wdata_reg;
      err_mem[addr_reg] <= prot_reg[3:2];
      meta[addr_reg].count <= cur.count + 24'h1;
      meta[addr_reg].rd_prot <= prot_reg[0];
      meta[addr_reg].wr_prot <= prot_reg[1];
      if (ctrl_wr[CMD_LOCK_ON_PROG])
        meta[addr_reg].locked <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      refused_reg <= 1'b0;
    else if (do_prog && !do_unlock)
      refused_reg <= cur.locked;
  end

  // read path: data or page status word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= 32'h0;
      rstat_reg <= RD_CLEAN;
    end
    else if (do_read && page_info)
    begin
      rdata_reg <= '0; // reserved 7:4 stay zero
      rdata_reg[PS_COUNT_LSB +: PS_COUNT_W] <= cur.count;
      rdata_reg[PS_OVER_BIT] <= cur.count > OVER_THRESHOLD;
      rdata_reg[PS_RDPROT_BIT] <= cur.rd_prot;
      rdata_reg[PS_WRPROT_BIT] <= cur.wr_prot;
      rdata_reg[PS_LOCK_BIT] <= cur.locked;
      rstat_reg <= RD_CLEAN;
    end
    else if (do_read)
    begin
      case (err_mem[addr_reg])
        RD_CORRECTED:
        begin
          rdata_reg <= data_mem[addr_reg]; // corrected data
          rstat_reg <= RD_CORRECTED;
        end
        RD_DOUBLE:
        begin
          // uncorrected: two stored bits (1:0) shown flipped
          rdata_reg <= data_mem[addr_reg] ^ 32'h3;
          rstat_reg <= RD_DOUBLE;
        end
        default:
        begin
          rdata_reg <= data_mem[addr_reg];
          rstat_reg <= RD_CLEAN;
        end
      endcase
    end
  end

  // events: set wins over a write-one clear
  always_comb
  begin
    ev = '0;
    ev[EV_DONE] = do_read || do_prog;
    ev[EV_CORR] = do_read && !page_info &&
      err_mem[addr_reg] == RD_CORRECTED;
    ev[EV_DOUBLE] = do_read && !page_info &&
      err_mem[addr_reg] == RD_DOUBLE;
    ev[EV_REFUSED] = do_prog && !do_unlock && cur.locked;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_reg <= '0;
    else if (wr && wb_adr_i == OFS_IRQ)
      irq_reg <= (irq_reg & ~wb_dat_i[EV_W-1:0]) | ev;
    else
      irq_reg <= irq_reg | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_reg & mask_reg);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_reg <= 32'h0;
    else if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        OFS_ADDR: dat_reg <= 32'(addr_reg);
        OFS_WDATA: dat_reg <= wdata_reg;
        OFS_RDATA: dat_reg <= rdata_reg;
        OFS_STATUS: dat_reg <= {29'h0, refused_reg, rstat_reg};
        OFS_IRQ: dat_reg <= {28'h0, irq_reg};
        OFS_MASK: dat_reg <= {28'h0, mask_reg};
        OFS_PROT: dat_reg <= {28'h0, prot_reg};
        default: dat_reg <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // bus handshake: one answer per request, one cycle long
  AST_ACK_ANSWER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  AST_ACK_ONE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // lock handling
  AST_LOCKED_NO_PROG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_prog && !do_unlock && cur.locked) |=>
    refused_reg && $stable(cur))
    else $error("program on locked page not refused");

  AST_UNLOCK: assert property (
    @(posedge clk_i) disable iff (rst_i)
    do_unlock |=> !cur.locked && $stable(cur.count))
    else $error("unlock failed or program not ignored");

  AST_LOCK_SET: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_prog && !do_unlock && !cur.locked && ctrl_wr[CMD_LOCK_ON_PROG])
    |=> cur.locked)
    else $error("lock flag not set");

  // program bookkeeping feeds the page status word
  AST_PROG_COUNT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_prog && !do_unlock && !cur.locked) |=>
    cur.count == $past(cur.count) + 24'h1)
    else $error("write count not advanced");

  AST_PROT_STORE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_prog && !do_unlock && !cur.locked) |=>
    cur.rd_prot == $past(prot_reg[0]) && cur.wr_prot == $past(prot_reg[1]))
    else $error("protect flags not stored");

  // page status word
  AST_RESERVED_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(do_read && page_info) |-> rdata_reg[7:4] == 4'h0)
    else $error("reserved bits not zero");

  AST_COUNT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_read && page_info) |=>
    rdata_reg[31:8] == $past(cur.count))
    else $error("write count wrong");

  AST_OVER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_read && page_info) |=>
    rdata_reg[3] == ($past(cur.count) > OVER_THRESHOLD))
    else $error("over threshold wrong");

  AST_PROT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_read && page_info) |=>
    rdata_reg[2:1] == $past({cur.rd_prot, cur.wr_prot}))
    else $error("protect flags wrong");

  AST_LOCK_BIT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_read && page_info) |=> rdata_reg[0] == $past(cur.locked))
    else $error("lock bit wrong");

  // data read status and returned word
  AST_CORR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ev[EV_CORR] |=> rstat_reg == 2'h1 ##1 irq_reg[EV_CORR])
    else $error("corrected status wrong");

  AST_CORR_DATA: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ev[EV_CORR] |=> rdata_reg == $past(cur_word))
    else $error("corrected data wrong");

  AST_DOUBLE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ev[EV_DOUBLE] |=> rstat_reg == 2'h2)
    else $error("double error status wrong");

  AST_DOUBLE_DATA: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ev[EV_DOUBLE] |=> rdata_reg == ($past(cur_word) ^ 32'h3))
    else $error("double error data was corrected");

  AST_CLEAN: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (do_read && !page_info && cur_err == 2'h0)
    |=> rstat_reg == 2'h0 && rdata_reg == $past(cur_word))
    else $error("clean status wrong");

  // sticky events and the interrupt line
  AST_EV_STICKY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (|ev) |=> (irq_reg & $past(ev)) == $past(ev))
    else $error("event not latched");

  AST_IRQ: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (|(irq_reg & mask_reg)) |=> irq_o)
    else $error("irq not raised");

  AST_IRQ_LOW: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(|(irq_reg & mask_reg)) |=> !irq_o)
    else $error("irq raised while all events masked or clear");
endmodule : flash_block_page_status
`default_nettype wire

// File: page_status_pkg.sv
// shared constants and carriers for the flash page status block
// assumes a single 20 MHz clock domain and a classic wishbone master
package page_status_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int ADDR_W = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_PROT = 8'h1c;
  // ctrl command bits (write-one pulses)
  localparam int CMD_READ = 0;
  localparam int CMD_PROG = 1;
  localparam int CMD_UNLOCK = 2;
  localparam int CMD_PAGEINFO = 3;
  localparam int CMD_LOCK_ON_PROG = 4;
  // read status codes
  localparam logic [1:0] RD_CLEAN = 2'h0;
  localparam logic [1:0] RD_CORRECTED = 2'h1;
  localparam logic [1:0] RD_DOUBLE = 2'h2;
  // page status word fields
  localparam int PS_COUNT_LSB = 8;
  localparam int PS_COUNT_W = 24;
  localparam int PS_OVER_BIT = 3;
  localparam int PS_RDPROT_BIT = 2;
  localparam int PS_WRPROT_BIT = 1;
  localparam int PS_LOCK_BIT = 0;
  localparam logic [23:0] OVER_THRESHOLD = 24'h000fff;
  // interrupt event bits
  localparam int EV_DONE = 0;
  localparam int EV_CORR = 1;
  localparam int EV_DOUBLE = 2;
  localparam int EV_REFUSED = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  typedef struct packed {
    logic [23:0] count;
    logic rd_prot;
    logic wr_prot;
    logic locked;
  } page_meta_t;
endpackage : page_status_pkg

// File: user_fabric_model.sv
// user fabric model: classic wishbone master issuing flash commands
// assumes a registered one-cycle ack on clk_i
`timescale 1ns/1ns
`default_nettype none
module user_fabric_model
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  import page_status_pkg::*;
  initial
  begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'h3, w};
    adr_o <= a;
    dat_o <= d;
    // no cycle budget here: a missing ack is left to the bench watchdog
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o, we_o} <= 3'h0;
    // released lines show junk, not the old value
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic status_word(input logic [7:0] p, output logic [31:0] q);
    wr(OFS_ADDR, {24'h0, p});
    wr(OFS_CTRL, (32'h1 << CMD_READ) | (32'h1 << CMD_PAGEINFO));
    rd(OFS_RDATA, q);
  endtask : status_word
  task automatic reprogram(input logic [7:0] p);
    wr(OFS_ADDR, {24'h0, p});
    wr(OFS_CTRL, 32'h1 << CMD_UNLOCK);
    wr(OFS_CTRL, 32'h1 << CMD_PROG);
  endtask : reprogram
endmodule : user_fabric_model
`default_nettype wire

// File: test_flash_block_page_status.sv
// bench for the flash page status block
// assumes the fabric model as the only bus master
`timescale 1ns/1ns
`default_nettype none
module test_flash_block_page_status;
  import page_status_pkg::*;
  typedef struct packed {
    logic [7:0] page;
    logic [1:0] inj;
    logic rdp;
    logic wrp;
    logic lk;
    logic [1:0] st;
  } row_t;
  row_t rows [4] = '{'{8'h01, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{8'h02, 2'h1, 1'b1, 1'b0, 1'b0, 2'h1},
    '{8'h03, 2'h2, 1'b0, 1'b1, 1'b1, 2'h2},
    '{8'h04, 2'h0, 1'b1, 1'b1, 1'b1, 2'h0}};
  row_t r;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, d;
  int n_errors = 0;
  int cmp_count = 0;
  user_fabric_model u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));
  flash_block_page_status i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    // over-threshold loop alone is some 12k cycles
    repeat (40000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    u.rd(OFS_MASK, q);
    chk(q, 32'h0);
    u.wr(8'h40, 32'hffff_ffff);
    u.rd(8'h40, q);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      r = rows[i];
      d = 32'ha5c3_0f00 + i;
      u.wr(OFS_ADDR, {24'h0, r.page});
      u.wr(OFS_WDATA, d);
      u.wr(OFS_PROT, {28'h0, r.inj, r.wrp, r.rdp});
      u.wr(OFS_CTRL, (32'(r.lk) << CMD_LOCK_ON_PROG) | (32'h1 << CMD_PROG));
      u.wr(OFS_CTRL, 32'h1 << CMD_READ);
      u.rd(OFS_RDATA, q);
      chk(q, (r.inj == 2'h2) ? d ^ 32'h3 : d);
      u.rd(OFS_STATUS, q);
      chk({30'h0, q[1:0]}, {30'h0, r.st});
      u.status_word(r.page, q);
      chk(q, {24'h1, 4'h0, 1'b0, r.rdp, r.wrp, r.lk});
    end
    u.wr(OFS_PROT, 32'h2);
    u.wr(OFS_ADDR, 32'h3);
    u.wr(OFS_CTRL, 32'h1 << CMD_PROG);
    u.rd(OFS_STATUS, q);
    chk({31'h0, q[2]}, 32'h1);
    u.status_word(8'h03, q);
    chk(q, {24'h1, 8'h03});
    u.reprogram(8'h03);
    u.status_word(8'h03, q);
    chk(q, {24'h2, 8'h02});
    u.rd(OFS_IRQ, q);
    chk(q, 32'hf);
    chk({31'h0, irq}, 32'h0);
    u.wr(OFS_MASK, 32'h8);
    repeat (3) @(negedge clk_i);
    chk({31'h0, irq}, 32'h1);
    u.wr(OFS_IRQ, 32'hf);
    repeat (3) @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    u.rd(OFS_IRQ, q);
    chk(q, 32'h0);
    u.wr(OFS_ADDR, 32'h4);
    u.wr(OFS_CTRL, (32'h1 << CMD_UNLOCK) | (32'h1 << CMD_PROG));
    u.status_word(8'h04, q);
    chk(q, {24'h1, 8'h06});
    u.wr(OFS_PROT, 32'h0);
    u.wr(OFS_ADDR, 32'h1);
    repeat (4094) u.wr(OFS_CTRL, 32'h1 << CMD_PROG);
    u.status_word(8'h01, q);
    chk(q, {24'hfff, 8'h00});
    u.wr(OFS_CTRL, 32'h1 << CMD_PROG);
    u.status_word(8'h01, q);
    chk(q, {24'h1000, 8'h08});
    // mid-run reset must clear flags, counts and the read port
    u.wr(OFS_MASK, 32'hf);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, ack}, 32'h0);
    chk(rdat, 32'h0);
    u.rd(OFS_IRQ, q);
    chk(q, 32'h0);
    u.rd(OFS_MASK, q);
    chk(q, 32'h0);
    u.status_word(8'h01, q);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule : test_flash_block_page_status
`default_nettype wire
